// file: common/cmo_cfg.svh
// register offsets, legal ranges and reset values of the controller
// assumes byte addressing on the register bus, one word per register
`ifndef CMO_CFG_SVH
`define CMO_CFG_SVH
`define CMO_OFS_CTRL     8'h00
`define CMO_OFS_TIMING   8'h04
`define CMO_OFS_STATUS   8'h08
`define CMO_OFS_CAUSE    8'h0c
`define CMO_OFS_OBJPEND  8'h10
`define CMO_OFS_TXREQ    8'h14
`define CMO_OFS_NEWDAT   8'h18
`define CMO_OFS_VALID    8'h1c
`define CMO_OFS_SEL      8'h20
`define CMO_OFS_ID       8'h24
`define CMO_OFS_MASK     8'h28
`define CMO_OFS_CFG      8'h2c
`define CMO_OFS_DLO      8'h30
`define CMO_OFS_DHI      8'h34
`define CMO_OFS_ACK      8'h38
`define CMO_SEG1_MIN     5'h02
`define CMO_SEG1_MAX     5'h10
`define CMO_SEG2_MIN     4'h1
`define CMO_SEG2_MAX     4'h8
`define CMO_SJW_MIN      3'h1
`define CMO_SJW_MAX      3'h4
`define CMO_PRE_MIN      10'h001
`define CMO_PRE_MAX      10'h3ff
`define CMO_SEG1_RST     5'h04
`define CMO_SEG2_RST     4'h2
`define CMO_SJW_RST      3'h1
`define CMO_PRE_RST      10'h001
`define CMO_CAUSE_STATUS 16'h8000
`define CMO_OBJS         32
`endif

// file: common/cmo_pkg.sv
// types shared by the controller and its bit timer
// constants live in cmo_cfg.svh
package cmo_pkg;
  typedef enum logic [2:0] {
    role_data_transmit,
    role_remote_request_transmit,
    role_data_receive,
    role_remote_request_receive,
    role_remote_auto_reply
  } cmo_role_t;

  typedef enum logic [2:0] {
    no_error_code,
    stuffing_error_code,
    format_error_code,
    ack_error_code,
    stuck_high_error_code,
    stuck_low_error_code,
    checksum_error_code
  } cmo_lec_t;

  typedef struct packed {
    logic        valid;
    logic        tx_ie;
    logic        rx_ie;
    logic        chain;
    logic        ext_filt;
    logic        dir_filt;
    logic        id_filt;
    logic        long_id;
    cmo_role_t   role;
  } cmo_obj_cfg_t;

  typedef struct packed {
    logic [28:0] id;
    logic        long_id;
    logic        remote;
    logic [3:0]  bytes;
    logic [63:0] data;
  } cmo_frame_t;

  typedef struct packed {
    logic [4:0]  seg1;
    logic [3:0]  seg2;
    logic [2:0]  sjw;
    logic [9:0]  presc;
  } cmo_timing_t;
endpackage

// file: src/cmo_bit_timer.sv
// quantum prescaler and bit segment sequencer
// assumes timing values already held inside their legal ranges
`timescale 1ns/1ps
module cmo_bit_timer import cmo_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire cmo_timing_t timing,
  input  wire logic        resync_late,
  output logic             tq_tick,
  output logic             bit_start,
  output logic             sample_tick
);
  logic [9:0] pc_r;
  logic [5:0] q_r;
  logic [2:0] ext_r;
  logic [5:0] len;

  // sync quantum is counted apart from seg1, ext_r and seg2, so the bit is seg1 + ext_r + seg2 + 1
  assign len = 6'(timing.seg1) + 6'(timing.seg2) + 6'(ext_r) + 6'h01;
  assign tq_tick = enable && (pc_r == timing.presc - 10'h001); // see (R4)

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable || tq_tick) begin
      pc_r <= 10'h000;
    end else begin
      pc_r <= pc_r + 10'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      q_r <= 6'h00;
    end else if (tq_tick) begin
      q_r <= (q_r == len - 6'h01) ? 6'h00 : q_r + 6'h01; // see (R25)
    end
  end

  // late edge stretches phase one by the jump width, once per bit
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      ext_r <= 3'h0;
    end else if (tq_tick && q_r == len - 6'h01) begin
      ext_r <= 3'h0;
    end else if (resync_late && q_r < 6'(timing.seg1)) begin
      ext_r <= timing.sjw; // see (R3)
    end
  end

  assign bit_start = tq_tick && q_r == 6'h00;
  assign sample_tick = tq_tick && q_r == 6'(timing.seg1) + 6'(ext_r);

  tq_period_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tq_tick && enable ##1 enable [*1] |-> pc_r == 10'h000) // see (R4)
    else $error("prescaler not restarted after quantum tick");
  bit_sync_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bit_start |-> !sample_tick) // see (R25)
    else $error("sample point fell in sync quantum");
endmodule

// file: src/cmo_ctrl.sv
// message object controller: registers, acceptance filter, tx arbiter
// assumes an external frame engine on sys_clk drives the event ports
//
// Behaviour
// (R1) first timing segment accepted from 2 to 16 quanta
// (R2) second phase segment accepted from 1 to 8 quanta
// (R3) jump width accepted from 1 to 4 quanta
// (R4) quantum is the clock divided by prescaler 1 to 1023
// (R5) object identifier is 11 or 29 bits by its long id flag
// (R6) object mask applies only while identifier filtering is on
// (R7) global enable cleared means no interrupt at all
// (R8) error and status interrupts each have their own enable
// (R9) bus-off entry sets a status flag
// (R10) warning and error passive levels set separate flags
// (R11) last error code holds the latest bus error kind
// (R12) receive success flag holds until status is read
// (R13) transmit success flag holds until status is read
// (R14) overrun flagged when unread contents are overwritten
// (R15) fresh flag marks new received contents in an object
// (R16) chained objects form a fifo, all but last flagged
// (R17) host enables id filtering whenever direction filtering is on
// (R18) host enables id filtering whenever long id filtering is on
// (R19) per object rx and tx interrupt enables read back
// (R20) tx request, new data and valid summaries, 32 bits each
// (R21) five object roles incl. remote reception with auto reply
// (R22) interrupt cause view and per object pending view
// (R23) 32 objects, lowest number served and reported first
// (R24) reading controller status clears the status interrupt
// (R25) sync is one quantum; bit is seg1 plus seg2 plus one
`timescale 1ns/1ps
`include "cmo_cfg.svh"
module cmo_ctrl import cmo_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_valid,
  input  wire cmo_frame_t  rx_frame,
  input  wire logic        tx_done,
  input  wire logic        err_evt,
  input  wire cmo_lec_t    err_code,
  input  wire logic        lvl_warn,
  input  wire logic        lvl_passive,
  input  wire logic        lvl_busoff,
  input  wire logic        resync_late,
  output logic             tx_pend,
  output logic [4:0]       tx_obj,
  output cmo_frame_t       tx_frame,
  output logic             ctrl_enable,
  output logic             tq_tick,
  output logic             sample_tick,
  output logic             bit_start,
  output logic             irq
);
  localparam int N = `CMO_OBJS;

  cmo_obj_cfg_t cfg_r [N];
  logic [28:0]  id_r [N];
  logic [28:0]  mask_r [N];
  logic [3:0]   bytes_r [N];
  logic [63:0]  data_r [N];
  logic [N-1:0] fresh_r, over_r, pend_r, txreq_r, match;
  logic [N-1:0] valid_v;
  cmo_timing_t  timing_r;
  logic         ack_r, ie_glb_r, ie_err_r, ie_sts_r;
  logic         rxok_r, txok_r, warn_r, pass_r, boff_r;
  logic         sts_pend_r, err_pend_r;
  cmo_lec_t     lec_r;
  logic [4:0]   sel_r, rx_obj, tx_lo;
  logic [5:0]   rx_low, tx_low;
  logic         rx_hit, tx_any, acc;
  logic         wr_go, rd_go;
  logic [31:0]  rd_nxt;

  function automatic logic [5:0] lowest(input logic [N-1:0] v);
    logic [5:0] r;
    r = 6'h20;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  // bus slave: one wait cycle, then the answer
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_go = avs_write && ack_r && avs_byteenable == 4'hf;
  assign rd_go = avs_read && ack_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // control and timing
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_enable <= 1'b0;
      ie_glb_r    <= 1'b0;
      ie_err_r    <= 1'b0;
      ie_sts_r    <= 1'b0;
    end else if (wr_go && avs_address == `CMO_OFS_CTRL) begin
      ctrl_enable <= avs_writedata[0];
      ie_glb_r    <= avs_writedata[1];
      ie_err_r    <= avs_writedata[2];
      ie_sts_r    <= avs_writedata[3];
    end
  end

  // out of range values are held at the nearest legal bound
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      timing_r <= '{`CMO_SEG1_RST, `CMO_SEG2_RST, `CMO_SJW_RST,
                    `CMO_PRE_RST};
    end else if (wr_go && avs_address == `CMO_OFS_TIMING) begin
      timing_r.seg1 <= avs_writedata[4:0] < `CMO_SEG1_MIN ? `CMO_SEG1_MIN
        : avs_writedata[4:0] > `CMO_SEG1_MAX ? `CMO_SEG1_MAX
        : avs_writedata[4:0]; // see (R1)
      timing_r.seg2 <= avs_writedata[11:8] < `CMO_SEG2_MIN ? `CMO_SEG2_MIN
        : avs_writedata[11:8] > `CMO_SEG2_MAX ? `CMO_SEG2_MAX
        : avs_writedata[11:8]; // see (R2)
      timing_r.sjw <= avs_writedata[14:12] < `CMO_SJW_MIN ? `CMO_SJW_MIN
        : avs_writedata[14:12] > `CMO_SJW_MAX ? `CMO_SJW_MAX
        : avs_writedata[14:12]; // see (R3)
      timing_r.presc <= avs_writedata[25:16] < `CMO_PRE_MIN ? `CMO_PRE_MIN
        : avs_writedata[25:16]; // see (R4)
    end
  end

  cmo_bit_timer u_timer (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .enable      (ctrl_enable),
    .timing      (timing_r),
    .resync_late (resync_late),
    .tq_tick     (tq_tick),
    .bit_start   (bit_start),
    .sample_tick (sample_tick)
  );

  // acceptance filter, one comparator per object
  for (genvar g = 0; g < N; g++) begin : g_obj
    logic [28:0] m, d;
    logic        rx_role, dir_ok, ext_ok;
    assign m = cfg_r[g].id_filt ? mask_r[g] : 29'h1fffffff; // see (R6)
    assign d = (rx_frame.id ^ id_r[g]) & m
             & (rx_frame.long_id ? 29'h1fffffff : 29'h000007ff); // see (R5)
    assign rx_role = cfg_r[g].role inside {role_data_receive,
      role_remote_request_receive, role_remote_auto_reply}; // see (R21)
    assign dir_ok = !cfg_r[g].dir_filt ||
      (rx_frame.remote == (cfg_r[g].role != role_data_receive));
    assign ext_ok = (cfg_r[g].id_filt && !cfg_r[g].ext_filt) ||
      rx_frame.long_id == cfg_r[g].long_id;
    // full chain members are skipped so the next one takes it
    assign match[g] = cfg_r[g].valid && rx_role && dir_ok && ext_ok &&
      d == 29'h0 && !(fresh_r[g] && cfg_r[g].chain); // see (R16)
    assign valid_v[g] = cfg_r[g].valid;
  end

  assign acc = rx_valid && ctrl_enable;
  assign rx_low = lowest(match);
  assign tx_low = lowest(txreq_r & valid_v);
  assign {rx_hit, rx_obj} = {!rx_low[5], rx_low[4:0]}; // see (R23)
  assign {tx_any, tx_lo} = {!tx_low[5], tx_low[4:0]};

  // object memory: configuration from software, contents from both
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        cfg_r[i]   <= '0;
        id_r[i]    <= 29'h0;
        mask_r[i]  <= 29'h0;
        bytes_r[i] <= 4'h0;
        data_r[i]  <= 64'h0;
      end
    end else begin
      if (acc && rx_hit && !rx_frame.remote) begin
        id_r[rx_obj]    <= rx_frame.id;
        bytes_r[rx_obj] <= rx_frame.bytes;
        data_r[rx_obj]  <= rx_frame.data;
      end
      if (wr_go) begin
        if (avs_address == `CMO_OFS_ID) begin
          id_r[sel_r] <= avs_writedata[28:0]; // see (R5)
        end else if (avs_address == `CMO_OFS_MASK) begin
          mask_r[sel_r] <= avs_writedata[28:0];
        end else if (avs_address == `CMO_OFS_CFG) begin
          cfg_r[sel_r]   <= cmo_obj_cfg_t'(avs_writedata[10:0]);
          bytes_r[sel_r] <= avs_writedata[19:16];
        end else if (avs_address == `CMO_OFS_DLO) begin
          data_r[sel_r][31:0] <= avs_writedata;
        end else if (avs_address == `CMO_OFS_DHI) begin
          data_r[sel_r][63:32] <= avs_writedata;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sel_r <= 5'h00;
    end else if (wr_go && avs_address == `CMO_OFS_SEL) begin
      sel_r <= avs_writedata[4:0];
    end
  end

  // per object flags; hardware set wins over the software ack
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fresh_r <= '0;
      over_r  <= '0;
      pend_r  <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (acc && rx_hit && rx_obj == 5'(i)) begin
          fresh_r[i] <= 1'b1; // see (R15)
          over_r[i]  <= over_r[i] || fresh_r[i]; // see (R14)
          pend_r[i]  <= pend_r[i] || cfg_r[i].rx_ie; // see (R19)
        end else if (tx_done && tx_obj == 5'(i)) begin
          pend_r[i]  <= pend_r[i] || cfg_r[i].tx_ie; // see (R19)
        end else if (wr_go && avs_address == `CMO_OFS_ACK &&
                     sel_r == 5'(i)) begin
          fresh_r[i] <= 1'b0;
          over_r[i]  <= 1'b0;
          pend_r[i]  <= 1'b0;
        end
      end
    end
  end

  // tx requests: software on cfg write, auto reply on remote frame
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txreq_r <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (acc && rx_hit && rx_obj == 5'(i) && rx_frame.remote &&
            cfg_r[i].role == role_remote_auto_reply) begin
          txreq_r[i] <= 1'b1; // see (R21)
        end else if (wr_go && avs_address == `CMO_OFS_CFG &&
                     sel_r == 5'(i)) begin
          txreq_r[i] <= avs_writedata[14];
        end else if (tx_done && tx_obj == 5'(i)) begin
          txreq_r[i] <= 1'b0;
        end
      end
    end
  end

  // transmit offer tracks the lowest request, frozen in the cycle the engine reports done
  assign tx_pend = tx_any && ctrl_enable;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_obj   <= 5'h00;
      tx_frame <= '0;
    end else if (!tx_done) begin
      tx_obj <= tx_lo; // see (R23)
      tx_frame <= '{id_r[tx_lo], cfg_r[tx_lo].long_id,
        cfg_r[tx_lo].role == role_remote_request_transmit,
        bytes_r[tx_lo], data_r[tx_lo]}; // see (R21)
    end
  end

  // controller status; a read clears the success flags
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxok_r <= 1'b0;
      txok_r <= 1'b0;
      lec_r  <= no_error_code;
    end else begin
      if (acc && rx_hit) begin
        rxok_r <= 1'b1; // see (R12)
      end else if (rd_go && avs_address == `CMO_OFS_STATUS) begin
        rxok_r <= 1'b0;
      end
      if (tx_done) begin
        txok_r <= 1'b1; // see (R13)
      end else if (rd_go && avs_address == `CMO_OFS_STATUS) begin
        txok_r <= 1'b0;
      end
      if (err_evt) begin
        lec_r <= err_code; // see (R11)
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      warn_r <= 1'b0;
      pass_r <= 1'b0;
      boff_r <= 1'b0;
    end else begin
      warn_r <= lvl_warn; // see (R10)
      pass_r <= lvl_passive; // see (R10)
      boff_r <= lvl_busoff; // see (R9)
    end
  end

  // interrupt classes: error on level rise or bus error, status on ok
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sts_pend_r <= 1'b0;
      err_pend_r <= 1'b0;
    end else begin
      if ((acc && rx_hit) || tx_done) begin
        sts_pend_r <= 1'b1;
      end else if (rd_go && avs_address == `CMO_OFS_STATUS) begin
        sts_pend_r <= 1'b0; // see (R24)
      end
      if (err_evt || (lvl_warn && !warn_r) || (lvl_passive && !pass_r) ||
          (lvl_busoff && !boff_r)) begin
        err_pend_r <= 1'b1;
      end else if (rd_go && avs_address == `CMO_OFS_STATUS) begin
        err_pend_r <= 1'b0; // see (R24)
      end
    end
  end

  assign irq = ie_glb_r && ((ie_sts_r && sts_pend_r) ||
    (ie_err_r && err_pend_r) || |pend_r); // see (R7) see (R8)

  // read mux, registered in the wait cycle
  always_comb begin
    rd_nxt = 32'h0;
    if (avs_address == `CMO_OFS_CTRL) begin
      rd_nxt = {28'h0, ie_sts_r, ie_err_r, ie_glb_r, ctrl_enable};
    end else if (avs_address == `CMO_OFS_TIMING) begin
      rd_nxt = {6'h0, timing_r.presc, 1'b0, timing_r.sjw,
                timing_r.seg2, 3'h0, timing_r.seg1};
    end else if (avs_address == `CMO_OFS_STATUS) begin
      rd_nxt = {24'h0, boff_r, pass_r, warn_r, rxok_r, txok_r,
                lec_r};
    end else if (avs_address == `CMO_OFS_CAUSE) begin
      rd_nxt = (sts_pend_r || err_pend_r) ? {16'h0, `CMO_CAUSE_STATUS}
        : (|pend_r) ? {26'h0, lowest(pend_r) + 6'h01} : 32'h0;
      // see (R22)
    end else if (avs_address == `CMO_OFS_OBJPEND) begin
      rd_nxt = pend_r; // see (R22)
    end else if (avs_address == `CMO_OFS_TXREQ) begin
      rd_nxt = txreq_r; // see (R20)
    end else if (avs_address == `CMO_OFS_NEWDAT) begin
      rd_nxt = fresh_r; // see (R20)
    end else if (avs_address == `CMO_OFS_VALID) begin
      rd_nxt = valid_v; // see (R20)
    end else if (avs_address == `CMO_OFS_SEL) begin
      rd_nxt = {27'h0, sel_r};
    end else if (avs_address == `CMO_OFS_ID) begin
      rd_nxt = {3'h0, id_r[sel_r]};
    end else if (avs_address == `CMO_OFS_MASK) begin
      rd_nxt = {3'h0, mask_r[sel_r]};
    end else if (avs_address == `CMO_OFS_CFG) begin
      rd_nxt = {12'h0, bytes_r[sel_r], 1'b0, txreq_r[sel_r],
                pend_r[sel_r], over_r[sel_r], fresh_r[sel_r],
                11'(cfg_r[sel_r])}; // see (R19)
    end else if (avs_address == `CMO_OFS_DLO) begin
      rd_nxt = data_r[sel_r][31:0];
    end else if (avs_address == `CMO_OFS_DHI) begin
      rd_nxt = data_r[sel_r][63:32];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rd_nxt;
    end
  end

  sequence s_status_read;
    rd_go && avs_address == `CMO_OFS_STATUS && !(acc && rx_hit) &&
      !tx_done;
  endsequence

  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !ie_glb_r |-> !irq) // see (R7)
    else $error("interrupt raised with global enable clear");
  sts_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_status_read |=> !rxok_r && !txok_r && !sts_pend_r) // see (R24)
    else $error("status read left status flags set");
  rxok_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc && rx_hit |=> rxok_r && fresh_r[$past(rx_obj)]) // see (R12)
    else $error("reception did not set ok and fresh");
  txok_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_done |=> txok_r && !txreq_r[$past(tx_obj)]) // see (R13)
    else $error("transmit done did not update flags");
  overrun_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    acc && rx_hit && fresh_r[rx_obj] |=> over_r[$past(rx_obj)])
    // see (R14)
    else $error("overwrite of unread object not flagged");
  lec_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    err_evt ##1 !err_evt [*2] |-> lec_r == $past(err_code, 2))
    // see (R11)
    else $error("last error code not held");
  bus_ans_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (avs_read || avs_write) && !ack_r |=> !avs_waitrequest)
    // see (R20)
    else $error("bus answer not given after one wait cycle");
  tx_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_any && !tx_done |=> tx_obj == $past(tx_lo)) // see (R23)
    else $error("transmit offer is not the lowest object");
  busoff_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(lvl_busoff) |=> boff_r && err_pend_r) // see (R9)
    else $error("bus-off entry not flagged");
endmodule

// file: dv/cmo_peer.sv
// far-side frame engine model: rx pulses, error pulses, tx completions
// assumes the controller on the same sys_clk; bench calls its tasks
`timescale 1ns/1ps
module cmo_peer import cmo_pkg::*; (
  input  wire logic       sys_clk,
  input  wire logic       tx_pend,
  input  wire logic [4:0] tx_obj,
  output logic            rx_valid,
  output cmo_frame_t      rx_frame,
  output logic            tx_done,
  output logic            err_evt,
  output cmo_lec_t        err_code,
  output logic            resync_late
);
  logic       hold = 1'b1;
  int         dly  = 3;
  int         wt   = 0;
  logic [4:0] sent[$];
  initial begin
    rx_valid = 1'b0;
    rx_frame = '1;
    tx_done = 1'b0;
    err_evt = 1'b0;
    err_code = no_error_code;
    resync_late = 1'b0;
  end
  // slow completion, held off until the bench lets frames go
  always @(posedge sys_clk) begin
    if (tx_pend && !hold && !tx_done && wt >= dly) begin
      tx_done <= 1'b1;
      sent.push_back(tx_obj);
      wt <= 0;
    end else begin
      tx_done <= 1'b0;
      if (tx_pend && !hold && !tx_done) begin
        wt <= wt + 1;
      end
    end
  end
  task automatic send_rx(cmo_frame_t f);
    @(posedge sys_clk);
    rx_frame <= f;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_frame <= ~f; // stale frame never looks valid
  endtask
  task automatic send_err(cmo_lec_t c);
    @(posedge sys_clk);
    err_code <= c;
    err_evt <= 1'b1;
    @(posedge sys_clk);
    err_evt <= 1'b0;
  endtask
  // one cycle late edge, caller starts it on a clock edge
  task automatic late();
    resync_late <= 1'b1;
    @(posedge sys_clk);
    resync_late <= 1'b0;
  endtask
endmodule

// file: dv/testbench.sv
// bench: avalon master, expectations from rules, scenario sequence
// assumes cmo_ctrl on 250 MHz sys_clk and the cmo_peer engine model
`timescale 1ns/1ps
`include "cmo_cfg.svh"
module testbench import cmo_pkg::*;;
  logic        sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic        lvl_warn = 0, lvl_passive = 0, lvl_busoff = 0;
  logic [7:0]  avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd, v, id;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        avs_waitrequest, rx_valid, tx_done, err_evt, resync_late;
  logic        tx_pend, ctrl_enable, tq_tick, sample_tick, bit_start, irq;
  logic [4:0]  tx_obj;
  logic [63:0] dt;
  cmo_frame_t  rx_frame, tx_frame;
  cmo_lec_t    err_code;
  int          fail_count = 0, checked = 0, cyc = 0, n, s1, s2, pr;
  cmo_ctrl DUT (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .rx_valid, .rx_frame, .tx_done, .err_evt, .err_code, .lvl_warn,
    .lvl_passive, .lvl_busoff, .resync_late, .tx_pend, .tx_obj,
    .tx_frame, .ctrl_enable, .tq_tick, .sample_tick, .bit_start, .irq);
  cmo_peer peer (.sys_clk, .tx_pend, .tx_obj, .rx_valid, .rx_frame,
    .tx_done, .err_evt, .err_code, .resync_late);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // opens on a fresh edge so strobes never change twice in one step
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, '0);
    chk(nm, rd, e);
  endtask
  task automatic per();
    n = 0;
    @(posedge sys_clk);
    while (!bit_start) @(posedge sys_clk);
    do begin
      @(posedge sys_clk);
      n++;
    end while (!bit_start);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    n = $urandom(32'hfff4);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc("timing", `CMO_OFS_TIMING, 32'h0001_1204);
    wr(`CMO_OFS_TIMING, 32'h0000_7f1f);
    rdc("tmax", `CMO_OFS_TIMING, 32'h0001_4810);
    wr(`CMO_OFS_TIMING, 32'h0);
    rdc("tmin", `CMO_OFS_TIMING, 32'h0001_1102);
    wr(`CMO_OFS_CTRL, 32'h1);
    repeat (3) begin
      s1 = 2 + $urandom % 15;
      s2 = 1 + $urandom % 8;
      pr = 1 + $urandom % 3;
      v = {6'h0, pr[9:0], 4'h1, s2[3:0], 3'h0, s1[4:0]};
      wr(`CMO_OFS_TIMING, v);
      rdc("timing", `CMO_OFS_TIMING, v);
      per();
      per();
      chk("bit", n, (s1 + s2 + 1) * pr);
    end
    v = {16'h1, 4'h4, s2[3:0], 3'h0, s1[4:0]};
    wr(`CMO_OFS_TIMING, v);
    per();
    peer.late();
    n = 1;
    pr = 0;
    while (!bit_start) begin
      if (sample_tick) pr = n;
      @(posedge sys_clk);
      n++;
    end
    chk("sjw", n, s1 + s2 + 5);
    chk("smp", pr, s1 + 4);
    wr(`CMO_OFS_SEL, 32'd7);
    for (int r = 0; r < 5; r++) begin
      wr(`CMO_OFS_CFG, r);
      rdc("role", `CMO_OFS_CFG, r);
    end
    wr(`CMO_OFS_CFG, 32'h0);
    id = $urandom % 2048;
    dt = {$urandom, $urandom};
    // no dir or ext filter without id filter
    for (int o = 5; o >= 2; o -= 3) begin
      wr(`CMO_OFS_SEL, o);
      wr(`CMO_OFS_ID, id);
      wr(`CMO_OFS_CFG, o == 2 ? 32'h582 : 32'h502);
    end
    rdc("ie", `CMO_OFS_CFG, 32'h582);
    repeat (3) peer.send_rx({id[28:0], 1'b0, 1'b0, 4'h8, dt});
    repeat (3) @(posedge sys_clk);
    chk("irq", irq, 1'b0);
    rdc("newdat", `CMO_OFS_NEWDAT, 32'h24);
    rdc("valid", `CMO_OFS_VALID, 32'h24);
    rdc("cfg2", `CMO_OFS_CFG, 32'h0008_2d82);
    rdc("dlo", `CMO_OFS_DLO, dt[31:0]);
    wr(`CMO_OFS_SEL, 32'd5);
    rdc("cfg5", `CMO_OFS_CFG, 32'h0008_3d02);
    rdc("sts", `CMO_OFS_STATUS, 32'h10);
    rdc("sts", `CMO_OFS_STATUS, 32'h0);
    wr(`CMO_OFS_CTRL, 32'h3);
    rdc("cause", `CMO_OFS_CAUSE, 32'h3);
    chk("irq", irq, 1'b1);
    rdc("pend", `CMO_OFS_OBJPEND, 32'h24);
    wr(`CMO_OFS_ACK, 32'h0);
    wr(`CMO_OFS_SEL, 32'd2);
    wr(`CMO_OFS_ACK, 32'h0);
    rdc("cause", `CMO_OFS_CAUSE, 32'h0);
    chk("irq", irq, 1'b0);
    wr(`CMO_OFS_CTRL, 32'h7);
    for (int c = 1; c < 7; c++) begin
      peer.send_err(cmo_lec_t'(c));
      rdc("cause", `CMO_OFS_CAUSE, `CMO_CAUSE_STATUS);
      chk("irq", irq, 1'b1);
      rdc("lec", `CMO_OFS_STATUS, c);
      @(posedge sys_clk);
      chk("irq", irq, 1'b0);
    end
    wr(`CMO_OFS_CTRL, 32'h3);
    peer.send_err(format_error_code);
    repeat (2) @(posedge sys_clk);
    chk("irq", irq, 1'b0);
    for (int l = 0; l < 3; l++) begin
      {lvl_busoff, lvl_passive, lvl_warn} <= 3'b1 << l;
      bus(1'b0, `CMO_OFS_STATUS, '0);
      chk("lvl", rd & 32'he0, 32'h20 << l);
    end
    {lvl_busoff, lvl_passive, lvl_warn} <= 3'b0;
    for (int o = 3; o > 0; o -= 2) begin
      wr(`CMO_OFS_SEL, o);
      wr(`CMO_OFS_ID, o);
      wr(`CMO_OFS_CFG, 32'h4600);
    end
    repeat (2) @(posedge sys_clk);
    chk("txobj", tx_obj, 5'd1);
    chk("txid", tx_frame.id, 32'd1);
    rdc("txreq", `CMO_OFS_TXREQ, 32'ha);
    peer.hold <= 1'b0;
    n = 0;
    while (peer.sent.size() < 2 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk("order", {peer.sent[0], peer.sent[1]}, 10'h023);
    rdc("txreq", `CMO_OFS_TXREQ, 32'h0);
    bus(1'b0, `CMO_OFS_STATUS, '0);
    chk("txok", rd & 32'h8, 32'h8);
    report_and_stop();
  end
endmodule
